// File: bench/can_engine_model.sv
// behavioural protocol engine and transceiver seen from the mode control block
`timescale 1ns/1ps
module can_engine_model
(
  input wire logic i_ref_clk, // bench clock
  input wire logic i_activity, // another node is sending
  input wire logic i_pending, // a frame waits in a transmit store
  input wire logic i_new_frame, // pulse: frame queued
  input wire logic [11:0] i_events, // event pulses
  output can_mode_pkg::engine_status_t o_engine, // engine status
  output logic o_rx_pin // receive line, 1 recessive
);
  logic [1:0] tick_cnt = 2'h0;
  logic toggle = 1'b0;
  always @(posedge i_ref_clk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    toggle <= ~toggle;
  end
  always_comb
  begin
    o_engine = '0;
    o_engine.bit_tick = (tick_cnt == 2'h3);
    o_engine.bus_idle = ~i_activity;
    o_engine.bus_activity = i_activity;
    o_engine.tx_pending = i_pending;
    o_engine.new_tx_frame = i_new_frame;
    o_engine.events = i_events;
    // nonzero counters so that a config hold is visible
    o_engine.error_counter = 16'h0105;
    o_engine.error_status = 5'h03;
    // a busy bus never shows a steady level
    o_rx_pin = i_activity ? toggle : 1'b1;
  end
endmodule

// File: bench/test_can_mode_reset_irq_control.sv
// self-checking bench for the can mode, reset and interrupt control block
`timescale 1ns/1ps
module test_can_mode_reset_irq_control;
  localparam logic [7:0] srr_a = can_mode_pkg::reset_control_addr;
  localparam logic [7:0] msr_a = can_mode_pkg::mode_select_addr;
  localparam logic [7:0] brp_a = can_mode_pkg::baud_prescaler_addr;
  localparam logic [7:0] isr_a = can_mode_pkg::interrupt_status_addr;
  localparam logic [7:0] ier_a = can_mode_pkg::interrupt_enable_addr;
  localparam logic [7:0] icr_a = can_mode_pkg::interrupt_clear_addr;
  logic i_ref_clk = 1'b0;
  logic i_soft_reset_bit = 1'b1;
  logic i_sys = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic act = 1'b0;
  logic pend = 1'b0;
  logic newf = 1'b0;
  logic [11:0] ev = 12'h000;
  can_mode_pkg::engine_status_t eng;
  logic rx;
  logic [31:0] o_rdata;
  logic o_tx_pin;
  logic o_irq;
  logic [3:0] o_mode_status;
  can_mode_pkg::engine_ctrl_t ctl;
  int num_errors = 0;
  int checks = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  can_engine_model peer (.i_ref_clk(i_ref_clk), .i_activity(act), .i_pending(pend),
    .i_new_frame(newf), .i_events(ev), .o_engine(eng), .o_rx_pin(rx));
  can_mode_ctrl dut (.i_ref_clk(i_ref_clk), .i_soft_reset_bit(i_soft_reset_bit), .i_ce(1'b1),
    .i_system_reset_in(i_sys), .i_rx_pin(rx), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_engine(eng), .o_rdata(o_rdata), .o_tx_pin(o_tx_pin),
    .o_interrupt_out(o_irq), .o_engine(ctl), .o_mode_status(o_mode_status));

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  task automatic pulse(input logic [11:0] e, input logic f);
    @(posedge i_ref_clk);
    ev <= e;
    newf <= f;
    @(posedge i_ref_clk);
    ev <= 12'h000;
    newf <= 1'b0;
  endtask

  // bounded wait, then the value is judged whatever it is
  task automatic wait_sig(input logic is_irq, input logic [3:0] exp);
    int n;
    n = 0;
    // let the edge that took the last strobe settle first
    #1;
    while ((is_irq ? {3'h0, o_irq} : o_mode_status) !== exp && n < 300)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    chk({28'h0, is_irq ? {3'h0, o_irq} : o_mode_status}, {28'h0, exp});
  endtask

  task automatic t_flags();
    chk({28'h0, o_mode_status}, 32'h1);
    chk({31'h0, o_tx_pin}, 32'h1);
    chk({31'h0, ctl.engine_run}, 32'h0);
    chk({31'h0, o_irq}, 32'h0);
    pulse(12'hfff, 1'b0);
    rdc(isr_a, 32'h82c);
    rdc(can_mode_pkg::error_counter_addr, 32'h0);
    chk({31'h0, o_irq}, 32'h0);
  endtask

  task automatic t_irq();
    wr(ier_a, 32'hc);
    wait_sig(1'b1, 4'h1);
    wr(icr_a, 32'h4);
    wait_sig(1'b1, 4'h0);
    wait_sig(1'b1, 4'h1);
    wr(ier_a, 32'h0);
    wait_sig(1'b1, 4'h0);
    wr(ier_a, 32'h8);
    wait_sig(1'b1, 4'h1);
    wr(icr_a, 32'hfff);
    wait_sig(1'b1, 4'h0);
    rdc(isr_a, 32'h0);
  endtask

  task automatic t_soft();
    wr(brp_a, 32'h12);
    rdc(brp_a, 32'h12);
    wr(can_mode_pkg::filter_mask_addr, 32'habcd);
    wr(srr_a, 32'h1);
    rdc(brp_a, 32'h0);
    rdc(srr_a, 32'h0);
    rdc(can_mode_pkg::filter_mask_addr, 32'habcd);
    rdc(8'h2c, 32'h0);
    chk({28'h0, o_mode_status}, 32'h1);
  endtask

  task automatic t_loop();
    wr(msr_a, 32'h2);
    wr(srr_a, 32'h2);
    // eleven ticks take over forty cycles
    repeat (20) @(posedge i_ref_clk);
    #1;
    chk({28'h0, o_mode_status}, 32'h1);
    wait_sig(1'b0, 4'h2);
    chk({31'h0, ctl.loopback}, 32'h1);
    wr(brp_a, 32'h55);
    rdc(brp_a, 32'h0);
    chk({31'h0, o_tx_pin}, 32'h1);
    wr(srr_a, 32'h0);
    wait_sig(1'b0, 4'h1);
  endtask

  task automatic t_sleep();
    wr(msr_a, 32'h1);
    wr(srr_a, 32'h2);
    wait_sig(1'b0, 4'h4);
    rdc(isr_a, 32'h200);
    @(posedge i_ref_clk);
    act <= 1'b1;
    wait_sig(1'b0, 4'h8);
    act <= 1'b0;
    chk({31'h0, ctl.engine_run}, 32'h1);
    rdc(can_mode_pkg::error_counter_addr, 32'h105);
    rdc(isr_a, 32'h600);
    wr(srr_a, 32'h0);
    wr(msr_a, 32'h1);
    wr(srr_a, 32'h2);
    wait_sig(1'b0, 4'h4);
    pulse(12'h000, 1'b1);
    wait_sig(1'b0, 4'h8);
    wr(srr_a, 32'h0);
    wr(msr_a, 32'h1);
    pend <= 1'b1;
    wr(srr_a, 32'h2);
    repeat (120) @(posedge i_ref_clk);
    #1;
    chk({31'h0, o_mode_status[2]}, 32'h0);
    pend <= 1'b0;
  endtask

  task automatic t_sys();
    wr(can_mode_pkg::filter_id_addr, 32'h77);
    @(posedge i_ref_clk);
    i_sys <= 1'b1;
    // no bus traffic while the pin is high
    repeat (10) @(posedge i_ref_clk);
    #1;
    chk({28'h0, o_mode_status}, 32'h1);
    i_sys <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    wait_sig(1'b0, 4'h1);
    rdc(srr_a, 32'h0);
    rdc(msr_a, 32'h0);
    rdc(can_mode_pkg::filter_id_addr, 32'h77);
  endtask

  initial
  begin
    repeat (8) @(posedge i_ref_clk);
    i_soft_reset_bit <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    t_flags();
    t_irq();
    t_soft();
    t_loop();
    t_sleep();
    t_sys();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    num_errors++;
    summarize();
  end
endmodule

// File: hdl/can_mode_ctrl.sv
// mode selection, soft reset, interrupt line and registers of the can controller
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module can_mode_ctrl
(
  input wire logic i_ref_clk, // 40 MHz clock
  input wire logic i_soft_reset_bit, // synchronous reset, active high
  input wire logic i_ce, // clock enable
  input wire logic i_system_reset_in, // async system reset pin
  input wire logic i_rx_pin, // receive line from transceiver
  input wire logic [7:0] i_addr, // register byte address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire can_mode_pkg::engine_status_t i_engine, // engine status
  output logic [31:0] o_rdata, // read data, cycle after strobe
  output logic o_tx_pin, // transmit line
  output logic o_interrupt_out, // interrupt line
  output can_mode_pkg::engine_ctrl_t o_engine, // engine controls
  output logic [3:0] o_mode_status // one-hot status
);
  typedef struct packed {
    logic [2:0] rst_sync;
    logic [2:0] rx_sync;
    logic soft_reset_bit;
    logic controller_enable_bit;
    logic sleep_select_bit;
    logic loopback_select_bit;
    logic [31:0] baud_prescaler;
    logic [31:0] bit_timing;
    logic [15:0] error_counter;
    logic [4:0] error_status;
    logic [11:0] interrupt_status_reg;
    logic [11:0] interrupt_enable_reg;
    logic [3:0] run_count;
    can_mode_pkg::mode_t mode;
    logic irq;
    logic [31:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [31:0] filter_mask_reg;
  logic [31:0] filter_id_reg;
  logic sys_rst;
  logic rx_level;
  logic in_reset;
  logic [11:0] irq_clr;
  logic [11:0] irq_set;
  logic irq_cond;
  logic irq_drop;

  // pin passes three flops; reset counts only while stages two and three are both high
  assign sys_rst = state_reg.rst_sync[1] & state_reg.rst_sync[2];
  assign in_reset = i_soft_reset_bit | sys_rst | state_reg.soft_reset_bit;

  always_comb
  begin
    state_next = state_reg;
    rx_level = state_reg.rx_sync[2];
    irq_clr = 12'h000;
    irq_set = i_engine.events;
    irq_cond = 1'b0;
    irq_drop = 1'b0;
    state_next.rst_sync = {state_reg.rst_sync[1:0], i_system_reset_in};
    state_next.rx_sync = {state_reg.rx_sync[1:0], i_rx_pin};
    if (state_reg.rx_sync[1] == state_reg.rx_sync[2])
    begin
      rx_level = state_reg.rx_sync[1];
    end
    state_next.rdata = 32'h0000_0000;
    if (i_rd)
    begin
      case (i_addr)
        can_mode_pkg::reset_control_addr:
          state_next.rdata = {30'h0, state_reg.controller_enable_bit, 1'b0};
        can_mode_pkg::mode_select_addr:
          state_next.rdata = {30'h0, state_reg.loopback_select_bit, state_reg.sleep_select_bit};
        can_mode_pkg::baud_prescaler_addr: state_next.rdata = state_reg.baud_prescaler;
        can_mode_pkg::bit_timing_addr: state_next.rdata = state_reg.bit_timing;
        can_mode_pkg::error_counter_addr: state_next.rdata = {16'h0, state_reg.error_counter};
        can_mode_pkg::error_status_addr: state_next.rdata = {27'h0, state_reg.error_status};
        can_mode_pkg::status_addr: state_next.rdata = {28'h0, o_mode_status};
        can_mode_pkg::interrupt_status_addr: state_next.rdata = {20'h0, state_reg.interrupt_status_reg};
        can_mode_pkg::interrupt_enable_addr: state_next.rdata = {20'h0, state_reg.interrupt_enable_reg};
        can_mode_pkg::filter_mask_addr: state_next.rdata = filter_mask_reg;
        can_mode_pkg::filter_id_addr: state_next.rdata = filter_id_reg;
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
    if (i_wr)
    begin
      case (i_addr)
        can_mode_pkg::reset_control_addr:
        begin
          state_next.soft_reset_bit = i_wdata[can_mode_pkg::soft_reset_pos];
          state_next.controller_enable_bit = i_wdata[can_mode_pkg::controller_enable_pos];
        end
        can_mode_pkg::mode_select_addr:
        begin
          // mode bits load only while disabled; while enabled a write can only clear the sleep bit
          if (!state_reg.controller_enable_bit)
          begin
            state_next.sleep_select_bit = i_wdata[can_mode_pkg::sleep_select_pos];
            state_next.loopback_select_bit = i_wdata[can_mode_pkg::loopback_select_pos];
          end
          else if (!i_wdata[can_mode_pkg::sleep_select_pos])
          begin
            state_next.sleep_select_bit = 1'b0;
          end
        end
        can_mode_pkg::baud_prescaler_addr:
          if (state_reg.mode == can_mode_pkg::mode_config)
          begin
            state_next.baud_prescaler = i_wdata;
          end
        can_mode_pkg::bit_timing_addr:
          if (state_reg.mode == can_mode_pkg::mode_config)
          begin
            state_next.bit_timing = i_wdata;
          end
        can_mode_pkg::interrupt_enable_addr: state_next.interrupt_enable_reg = i_wdata[11:0];
        can_mode_pkg::interrupt_clear_addr: irq_clr = i_wdata[11:0];
        default: irq_clr = 12'h000;
      endcase
    end
    // error registers track the engine in every mode except config
    if (state_reg.mode == can_mode_pkg::mode_config)
    begin
      state_next.error_counter = can_mode_pkg::error_counter_rst;
      state_next.error_status = can_mode_pkg::error_status_rst;
      irq_set = i_engine.events & ~can_mode_pkg::config_clear_mask;
      irq_clr = irq_clr | can_mode_pkg::config_clear_mask;
    end
    else
    begin
      state_next.error_counter = i_engine.error_counter;
      state_next.error_status = i_engine.error_status;
    end
    // mode machine; config holds until enable plus eleven recessive bits
    case (state_reg.mode)
      can_mode_pkg::mode_config:
      begin
        if (state_reg.controller_enable_bit && i_engine.bit_tick)
        begin
          if (!rx_level)
          begin
            state_next.run_count = 4'h0;
          end
          else if (state_reg.run_count != can_mode_pkg::recessive_run_len)
          begin
            state_next.run_count = state_reg.run_count + 4'h1;
          end
        end
        if (state_reg.controller_enable_bit
            && state_reg.run_count == can_mode_pkg::recessive_run_len)
        begin
          if (state_reg.loopback_select_bit)
          begin
            state_next.mode = can_mode_pkg::mode_loopback;
          end
          else if (state_reg.sleep_select_bit && !i_engine.tx_pending)
          begin
            state_next.mode = can_mode_pkg::mode_sleep;
            irq_set[can_mode_pkg::sleep_entered_pos] = 1'b1;
          end
          else if (!state_reg.sleep_select_bit)
          begin
            state_next.mode = can_mode_pkg::mode_normal;
          end
        end
      end
      can_mode_pkg::mode_normal:
        if (state_reg.sleep_select_bit && i_engine.bus_idle && !i_engine.tx_pending)
        begin
          state_next.mode = can_mode_pkg::mode_sleep;
          irq_set[can_mode_pkg::sleep_entered_pos] = 1'b1;
        end
      can_mode_pkg::mode_sleep:
        if (!state_reg.sleep_select_bit || i_engine.bus_activity || i_engine.new_tx_frame)
        begin
          state_next.mode = can_mode_pkg::mode_normal;
          state_next.sleep_select_bit = 1'b0;
          irq_set[can_mode_pkg::wakeup_pos] = 1'b1;
        end
      can_mode_pkg::mode_loopback: state_next.mode = can_mode_pkg::mode_loopback;
      default: state_next.mode = can_mode_pkg::mode_config;
    endcase
    if (!state_reg.controller_enable_bit)
    begin
      state_next.mode = can_mode_pkg::mode_config;
      state_next.run_count = 4'h0;
    end
    // set wins over clear
    state_next.interrupt_status_reg = (state_reg.interrupt_status_reg & ~irq_clr) | irq_set;
    irq_cond = |(state_next.interrupt_status_reg & state_next.interrupt_enable_reg);
    irq_drop = |(state_reg.interrupt_status_reg & state_reg.interrupt_enable_reg & (irq_clr | ~state_next.interrupt_enable_reg));
    state_next.irq = irq_cond & ~(irq_drop & state_reg.irq);
    if (in_reset)
    begin
      // filters and synchronisers are kept outside this default set
      state_next.soft_reset_bit = 1'b0;
      state_next.controller_enable_bit = 1'b0;
      state_next.sleep_select_bit = 1'b0;
      state_next.loopback_select_bit = 1'b0;
      state_next.baud_prescaler = can_mode_pkg::baud_prescaler_rst;
      state_next.bit_timing = can_mode_pkg::bit_timing_rst;
      state_next.error_counter = can_mode_pkg::error_counter_rst;
      state_next.error_status = can_mode_pkg::error_status_rst;
      state_next.interrupt_status_reg = 12'h000;
      state_next.interrupt_enable_reg = 12'h000;
      state_next.run_count = 4'h0;
      state_next.mode = can_mode_pkg::mode_config;
      state_next.irq = 1'b0;
    end
    if (i_soft_reset_bit)
    begin
      state_next.rst_sync = 3'h0;
      state_next.rx_sync = 3'h7;
      state_next.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_ce)
    begin
      state_reg <= state_next;
      // not part of the reset set, survives both resets
      if (i_wr && i_addr == can_mode_pkg::filter_mask_addr)
      begin
        filter_mask_reg <= i_wdata;
      end
      if (i_wr && i_addr == can_mode_pkg::filter_id_addr)
      begin
        filter_id_reg <= i_wdata;
      end
    end
  end

  always_comb
  begin
    o_mode_status = 4'h0;
    case (state_reg.mode)
      can_mode_pkg::mode_config: o_mode_status[can_mode_pkg::st_config_pos] = 1'b1;
      can_mode_pkg::mode_loopback: o_mode_status[can_mode_pkg::st_loopback_pos] = 1'b1;
      can_mode_pkg::mode_sleep: o_mode_status[can_mode_pkg::st_sleep_pos] = 1'b1;
      can_mode_pkg::mode_normal: o_mode_status[can_mode_pkg::st_normal_pos] = 1'b1;
      default: o_mode_status[can_mode_pkg::st_config_pos] = 1'b1;
    endcase
  end

  assign o_rdata = state_reg.rdata;
  assign o_interrupt_out = state_reg.irq;
  // transmit is held recessive in every mode; engine drives frames internally in loopback
  assign o_tx_pin = 1'b1;
  assign o_engine.engine_run = state_reg.mode == can_mode_pkg::mode_normal
                               || state_reg.mode == can_mode_pkg::mode_loopback;
  assign o_engine.loopback = state_reg.mode == can_mode_pkg::mode_loopback;
  assign o_engine.hold_errors = state_reg.mode == can_mode_pkg::mode_config;
  assign o_engine.baud_prescaler = state_reg.baud_prescaler;
  assign o_engine.bit_timing = state_reg.bit_timing;

  a_reset_config: assert property (@(posedge i_ref_clk) i_soft_reset_bit |=> o_mode_status == 4'h1)
    else $error("reset left config");
  a_soft_reset: assert property (@(posedge i_ref_clk) disable iff (i_soft_reset_bit)
    (i_ce && state_reg.soft_reset_bit) |=> o_mode_status == 4'h1 && !state_reg.soft_reset_bit)
    else $error("soft reset missed");
  a_onehot_status: assert property (@(posedge i_ref_clk) disable iff (i_soft_reset_bit)
    $onehot(o_mode_status)) else $error("status not one-hot");
  a_config_errors: assert property (@(posedge i_ref_clk) disable iff (i_soft_reset_bit)
    (i_ce && state_reg.mode == can_mode_pkg::mode_config) |=> state_reg.error_counter == 16'h0)
    else $error("error counter not held");
  a_config_flags: assert property (@(posedge i_ref_clk) disable iff (i_soft_reset_bit)
    (i_ce && state_reg.mode == can_mode_pkg::mode_config
     && state_next.mode == can_mode_pkg::mode_config)
    |=> (state_reg.interrupt_status_reg & can_mode_pkg::config_clear_mask) == 12'h0)
    else $error("event flags kept");
  a_run_exit: assert property (@(posedge i_ref_clk) disable iff (i_soft_reset_bit)
    (state_reg.mode == can_mode_pkg::mode_config
     && state_reg.run_count != can_mode_pkg::recessive_run_len)
    |=> state_reg.mode != can_mode_pkg::mode_normal)
    else $error("left config early");
  a_loop_exit: assert property (@(posedge i_ref_clk) disable iff (i_soft_reset_bit)
    (state_reg.mode == can_mode_pkg::mode_loopback)
    |=> state_reg.mode inside {can_mode_pkg::mode_loopback, can_mode_pkg::mode_config})
    else $error("bad loopback exit");
  a_irq_drop: assert property (@(posedge i_ref_clk) disable iff (i_soft_reset_bit)
    (i_ce && state_reg.irq && irq_drop) |=> !o_interrupt_out)
    else $error("irq not dropped");
  a_irq_rise: assert property (@(posedge i_ref_clk) disable iff (i_soft_reset_bit || in_reset)
    (i_ce && !state_reg.irq && |(state_reg.interrupt_status_reg & state_reg.interrupt_enable_reg)) |=> o_interrupt_out)
    else $error("irq not raised");
  c_enter_normal: cover property (@(posedge i_ref_clk) state_reg.mode == can_mode_pkg::mode_normal);
  c_enter_sleep: cover property (@(posedge i_ref_clk) state_reg.mode == can_mode_pkg::mode_sleep);
  c_loopback: cover property (@(posedge i_ref_clk) state_reg.mode == can_mode_pkg::mode_loopback);
  c_irq_pulse: cover property (@(posedge i_ref_clk) state_reg.irq ##1 !state_reg.irq ##1 state_reg.irq);
endmodule

// File: hdl/can_mode_pkg.sv
// constants, types and layouts for the can mode, reset and interrupt control block
package can_mode_pkg;
  localparam logic [7:0] reset_control_addr = 8'h00;
  localparam logic [7:0] mode_select_addr = 8'h04;
  localparam logic [7:0] baud_prescaler_addr = 8'h08;
  localparam logic [7:0] bit_timing_addr = 8'h0c;
  localparam logic [7:0] error_counter_addr = 8'h10;
  localparam logic [7:0] error_status_addr = 8'h14;
  localparam logic [7:0] status_addr = 8'h18;
  localparam logic [7:0] interrupt_status_addr = 8'h1c;
  localparam logic [7:0] interrupt_enable_addr = 8'h20;
  localparam logic [7:0] interrupt_clear_addr = 8'h24;
  localparam logic [7:0] filter_mask_addr = 8'h64;
  localparam logic [7:0] filter_id_addr = 8'h68;
  // reset_control bits
  localparam int soft_reset_pos = 0;
  localparam int controller_enable_pos = 1;
  // mode_select bits
  localparam int sleep_select_pos = 0;
  localparam int loopback_select_pos = 1;
  // status bits
  localparam int st_config_pos = 0;
  localparam int st_loopback_pos = 1;
  localparam int st_sleep_pos = 2;
  localparam int st_normal_pos = 3;
  // interrupt bits
  localparam int arbitration_lost_pos = 0;
  localparam int transmit_done_pos = 1;
  localparam int priority_buffer_full_pos = 2;
  localparam int transmit_fifo_full_pos = 3;
  localparam int receive_done_pos = 4;
  localparam int receive_underflow_pos = 5;
  localparam int receive_overflow_pos = 6;
  localparam int error_pos = 7;
  localparam int bus_off_pos = 8;
  localparam int sleep_entered_pos = 9;
  localparam int wakeup_pos = 10;
  localparam int receive_not_empty_pos = 11;
  localparam int irq_width = 12;
  localparam logic [11:0] config_clear_mask = 12'h7d3;
  localparam logic [3:0] recessive_run_len = 4'hb;
  localparam logic [31:0] baud_prescaler_rst = 32'h0000_0000;
  localparam logic [31:0] bit_timing_rst = 32'h0000_0000;
  localparam logic [15:0] error_counter_rst = 16'h0000;
  localparam logic [4:0] error_status_rst = 5'h00;

  typedef enum logic [1:0] {
    mode_config = 2'b00,
    mode_normal = 2'b01,
    mode_sleep = 2'b10,
    mode_loopback = 2'b11
  } mode_t;

  // events and levels from the protocol engine
  typedef struct packed {
    logic bit_tick;
    logic bus_idle;
    logic bus_activity;
    logic tx_pending;
    logic new_tx_frame;
    logic [irq_width-1:0] events;
    logic [15:0] error_counter;
    logic [4:0] error_status;
  } engine_status_t;

  // controls to the protocol engine
  typedef struct packed {
    logic engine_run;
    logic loopback;
    logic hold_errors;
    logic [31:0] baud_prescaler;
    logic [31:0] bit_timing;
  } engine_ctrl_t;
endpackage
